// [logic/irc_pkg.sv]
// Package: register map, field layout and defaults for input conditioning
package irc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int IRC_NUM_INPUTS = 5;
    localparam int IRC_ADDR_W = 8;
    localparam int IRC_DATA_W = 8;
    localparam int IRC_IDX_W = 3;

    // Index 0 first single-ended input, then second TTL, two DIFF, third
    localparam logic [IRC_NUM_INPUTS-1:0][IRC_ADDR_W-1:0] IRC_CFG_OFFSET = {
        8'h28, 8'h25, 8'h24, 8'h23, 8'h22
    };
    localparam logic [IRC_NUM_INPUTS-1:0][IRC_DATA_W-1:0] IRC_CFG_RESET = {
        8'h03, 8'h03, 8'h03, 8'h00, 8'h00
    };
    localparam logic [IRC_IDX_W-1:0] IRC_IDX_MISS = 3'h7;
    localparam logic [IRC_DATA_W-1:0] IRC_UNMAPPED_DATA = 8'h00;

    // ------------------------------------------------------------------
    // Field layout, bit 7 down to bit 0
    // ------------------------------------------------------------------
    typedef struct packed {
        logic prog_prediv_select;              // Bit 7
        logic fixed_prediv_select;             // Bit 6
        logic [1:0] activity_monitor_profile;  // Bits 5:4
        logic [3:0] ref_freq_select;           // Bits 3:0, stored only
    } irc_cfg_t;

    // Per-input routed references
    typedef struct packed {
        logic loop_ref;
        logic monitor_ref;
    } irc_route_t;

endpackage

// [logic/irc_prediv.sv]
// Edge-counting pre-divider for one synchronous reference input
`timescale 1ns/1ps

module irc_prediv
    import irc_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ref_in,
    input wire logic [DIV_W-1:0] ratio,
    output logic div_out
);

    logic prev_reg;
    logic prev_next;
    logic [DIV_W-1:0] count_reg;
    logic [DIV_W-1:0] count_next;
    logic out_reg;
    logic out_next;
    logic rise;
    logic last;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Ratio 0 or 1 passes the input through, one cycle late
    always_comb begin
        rise = ref_in & ~prev_reg;
        last = (ratio <= {{(DIV_W-1){1'b0}}, 1'b1})
            || (count_reg >= ratio - {{(DIV_W-1){1'b0}}, 1'b1});
        prev_next = ref_in;
        count_next = count_reg;
        if (rise) begin
            count_next = last ? '0 : count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
        end
        // Only the high phase that opens a new period gets through
        out_next = ref_in & (count_next == '0);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
            count_reg <= '0;
            out_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            count_reg <= count_next;
            out_reg <= out_next;
        end
    end

    assign div_out = out_reg;

endmodule // irc_prediv

// [logic/irc_input_ref_conditioning_cfg.sv]
// Per-input reference conditioning configuration registers and routing
//
// Overview of operation
// (R1) Programmable-divide bit set routes input via divider to loop and monitor.
// (R2) Fixed-division bit set routes input via preset divider to loop only.
// (R3) Fixed division brings the loop reference down to an 8 kHz rate.
// (R4) Fixed-division bit is ignored while the programmable-divide bit is set.
// (R5) Every timing input has its own activity monitor, nothing shared.
// (R6) Two-bit field picks monitor configuration zero to three for the input.
// (R7) Register layout repeats per input at its own address and default.
// (R8) Reads return the last written value of all fields, else defaults.
`timescale 1ns/1ps

module irc_input_ref_conditioning_cfg
    import irc_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [IRC_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [IRC_DATA_W-1:0] reg_wdata,
    output logic [IRC_DATA_W-1:0] reg_rdata,
    input wire logic [DIV_W-1:0] prog_div_ratio,
    input wire logic [DIV_W-1:0] fixed_div_ratio,
    input wire logic [IRC_NUM_INPUTS-1:0] ref_in,
    output logic [IRC_NUM_INPUTS-1:0] loop_ref,
    output logic [IRC_NUM_INPUTS-1:0] monitor_ref,
    output logic [IRC_NUM_INPUTS-1:0][1:0] activity_monitor_profile
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (DIV_W < 2) begin : g_bad_div_w
        $error("DIV_W must be at least 2");
    end

    // Miss code must stay clear of every real input index
    if (IRC_NUM_INPUTS >= (1 << IRC_IDX_W)) begin : g_bad_idx_w
        $error("IRC_IDX_W too narrow for the input count");
    end
    if (int'(IRC_IDX_MISS) < IRC_NUM_INPUTS) begin : g_bad_miss
        $error("IRC_IDX_MISS collides with an input index");
    end

    // Stored fields must fill exactly one register byte
    if ($bits(irc_cfg_t) != IRC_DATA_W) begin : g_bad_cfg_w
        $error("irc_cfg_t width differs from IRC_DATA_W");
    end

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;
    logic rst_meta_next;
    logic rst_sync_next;

    // Ones shift in at the meta stage; only the second stage reads it
    always_comb begin
        rst_meta_next = 1'b1;
        rst_sync_next = rst_meta_reg;
    end

    // Async assert, release after two edges to avoid metastable release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= rst_meta_next;
            rst_sync_reg <= rst_sync_next;
        end
    end

    assign rst_n = rst_sync_reg;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Returns the input index of a mapped offset, or the miss code
    function automatic logic [IRC_IDX_W-1:0] irc_decode(
        input logic [IRC_ADDR_W-1:0] addr
    );
        logic [IRC_IDX_W-1:0] idx;
        idx = IRC_IDX_MISS;
        if (addr == IRC_CFG_OFFSET[0]) begin
            idx = 3'h0;
        end else if (addr == IRC_CFG_OFFSET[1]) begin
            idx = 3'h1;
        end else if (addr == IRC_CFG_OFFSET[2]) begin
            idx = 3'h2;
        end else if (addr == IRC_CFG_OFFSET[3]) begin
            idx = 3'h3;
        end else if (addr == IRC_CFG_OFFSET[4]) begin
            idx = 3'h4;
        end
        return idx;
    endfunction

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    irc_cfg_t [IRC_NUM_INPUTS-1:0] cfg_reg;
    irc_cfg_t [IRC_NUM_INPUTS-1:0] cfg_next;
    logic [IRC_DATA_W-1:0] rdata_reg;
    logic [IRC_DATA_W-1:0] rdata_next;
    logic [IRC_IDX_W-1:0] wr_idx;
    logic [IRC_IDX_W-1:0] rd_idx;

    // Whole byte stored, frequency field included, so reads echo it
    always_comb begin
        wr_idx = irc_decode(reg_addr);
        rd_idx = irc_decode(reg_addr);
        cfg_next = cfg_reg;
        if (reg_wr && (wr_idx != IRC_IDX_MISS)) begin
            cfg_next[wr_idx] = irc_cfg_t'(reg_wdata); // [R7] [R8]
        end
        rdata_next = rdata_reg;
        if (reg_rd) begin
            if (rd_idx != IRC_IDX_MISS) begin
                rdata_next = cfg_reg[rd_idx]; // [R8]
            end else begin
                rdata_next = IRC_UNMAPPED_DATA;
            end
        end
    end

    // Each input comes out of reset with its own default
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= IRC_CFG_RESET; // [R7] [R8]
            rdata_reg <= '0;
        end else begin
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ------------------------------------------------------------------
    // Per-input routing
    // ------------------------------------------------------------------
    irc_route_t [IRC_NUM_INPUTS-1:0] route_reg;
    irc_route_t [IRC_NUM_INPUTS-1:0] route_next;
    logic [IRC_NUM_INPUTS-1:0] ref_dly_reg;
    logic [IRC_NUM_INPUTS-1:0] ref_dly_next;
    logic [IRC_NUM_INPUTS-1:0] prog_out;
    logic [IRC_NUM_INPUTS-1:0] fixed_out;

    // Separate divider state per input; fixed ratio targets 8 kHz
    for (genvar i = 0; i < IRC_NUM_INPUTS; i++) begin : g_input
        irc_prediv #(
            .DIV_W(DIV_W)
        ) u_prog_div (
            .clk(clk),
            .rst_n(rst_n),
            .ref_in(ref_in[i]),
            .ratio(prog_div_ratio),
            .div_out(prog_out[i])
        ); // [R1] [R5]
        irc_prediv #(
            .DIV_W(DIV_W)
        ) u_fixed_div (
            .clk(clk),
            .rst_n(rst_n),
            .ref_in(ref_in[i]),
            .ratio(fixed_div_ratio),
            .div_out(fixed_out[i])
        ); // [R2] [R3] [R5]
    end

    // Undivided path delayed one cycle to match the divider latency
    always_comb begin
        ref_dly_next = ref_in;
        for (int i = 0; i < IRC_NUM_INPUTS; i++) begin
            if (cfg_reg[i].prog_prediv_select) begin
                // Programmable path wins, fixed bit not looked at
                route_next[i].loop_ref = prog_out[i]; // [R1] [R4]
                route_next[i].monitor_ref = prog_out[i]; // [R1]
            end else begin
                route_next[i].monitor_ref = ref_dly_reg[i]; // [R1] [R2]
                if (cfg_reg[i].fixed_prediv_select) begin
                    route_next[i].loop_ref = fixed_out[i]; // [R2] [R3]
                end else begin
                    route_next[i].loop_ref = ref_dly_reg[i]; // [R2]
                end
            end
        end
    end

    // Route register closes every path, so direct and divided
    // references leave with the same two-cycle latency; a switch of
    // path never skews the loop against the monitor
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_dly_reg <= '0;
            route_reg <= '0;
        end else begin
            ref_dly_reg <= ref_dly_next;
            route_reg <= route_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Profile straight from the stored field, one per input
    always_comb begin
        for (int i = 0; i < IRC_NUM_INPUTS; i++) begin
            loop_ref[i] = route_reg[i].loop_ref;
            monitor_ref[i] = route_reg[i].monitor_ref;
            activity_monitor_profile[i] =
                cfg_reg[i].activity_monitor_profile; // [R5] [R6]
        end
    end

endmodule // irc_input_ref_conditioning_cfg

// [testbench/irc_cfg_asserts.sv]
// Checker for the input conditioning configuration block ports
`timescale 1ns/1ps

module irc_cfg_asserts
    import irc_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [IRC_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [IRC_DATA_W-1:0] reg_wdata,
    input wire logic [IRC_DATA_W-1:0] reg_rdata,
    input wire logic [DIV_W-1:0] prog_div_ratio,
    input wire logic [DIV_W-1:0] fixed_div_ratio,
    input wire logic [IRC_NUM_INPUTS-1:0] ref_in,
    input wire logic [IRC_NUM_INPUTS-1:0] loop_ref,
    input wire logic [IRC_NUM_INPUTS-1:0] monitor_ref,
    input wire logic [IRC_NUM_INPUTS-1:0][1:0] activity_monitor_profile
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Shadow of the first input's register, so routing can be judged
    logic [7:0] cfg0_reg;
    logic [7:0] cfg0_next;
    always_comb begin
        cfg0_next = (reg_wr && reg_addr == 8'h22) ? reg_wdata : cfg0_reg;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cfg0_reg <= IRC_CFG_RESET[0];
        else cfg0_reg <= cfg0_next;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // Config held three samples covers the two-stage routing pipe
    property p_profile;
        reg_wr && reg_addr == 8'h22 |=>
            activity_monitor_profile[0] == $past(reg_wdata[5:4]);
    endproperty
    a_profile: assert property (p_profile)
        else $error("profile does not follow written field");
    property p_unmapped;
        reg_rd && reg_addr == 8'h26 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rd_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");
    property p_loop_direct;
        (cfg0_reg[7:6] == 2'b00) [*3] |-> loop_ref[0] == $past(ref_in[0], 2);
    endproperty
    a_loop_direct: assert property (p_loop_direct)
        else $error("loop reference not passed straight");
    property p_mon_direct;
        (!cfg0_reg[7]) [*3] |-> monitor_ref[0] == $past(ref_in[0], 2);
    endproperty
    a_mon_direct: assert property (p_mon_direct)
        else $error("monitor reference not passed straight");
    property p_prog_high;
        (cfg0_reg[7]) [*3] |-> !monitor_ref[0] || $past(ref_in[0], 2);
    endproperty
    a_prog_high: assert property (p_prog_high)
        else $error("divided monitor pulse outside input high");
    property p_fixed_high;
        (cfg0_reg[7:6] == 2'b01) [*3] |-> !loop_ref[0] || $past(ref_in[0], 2);
    endproperty
    a_fixed_high: assert property (p_fixed_high)
        else $error("fixed divided pulse outside input high");
    property p_prio;
        (cfg0_reg[7:6] == 2'b11) [*3] |-> loop_ref[0] == monitor_ref[0];
    endproperty
    a_prio: assert property (p_prio)
        else $error("loop and monitor differ under programmable divide");
endmodule // irc_cfg_asserts

// [testbench/irc_input_ref_conditioning_cfg_tb.sv]
// Testbench for the input conditioning configuration block
`timescale 1ns/1ps

module irc_input_ref_conditioning_cfg_tb;
    import irc_pkg::*;
    localparam logic [4:0][7:0] VALS = {8'hf5, 8'h3d, 8'h2c, 8'h1b, 8'h0a};
    localparam logic [4:0][7:0] DFLT = IRC_CFG_RESET;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [4:0] ref_in = '0;
    logic [4:0] loop_ref;
    logic [4:0] monitor_ref;
    logic [4:0] loop_d = '0;
    logic [4:0] mon_d = '0;
    logic [4:0][1:0] activity_monitor_profile;
    int num_errors = 0;
    int checks_done = 0;
    int n_loop[5];
    int n_mon[5];
    logic [3:0] prog_ratio = 4'h2;
    always #20 clk = ~clk;
    irc_input_ref_conditioning_cfg #(.DIV_W(4)) dut (.clk(clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .prog_div_ratio(prog_ratio), .fixed_div_ratio(4'h4), .ref_in(ref_in),
        .loop_ref(loop_ref), .monitor_ref(monitor_ref),
        .activity_monitor_profile(activity_monitor_profile));
    // Count output rising edges at the falling edge, once settled
    always @(negedge clk) begin
        for (int i = 0; i < 5; i++) begin
            if (loop_ref[i] && !loop_d[i]) n_loop[i]++;
            if (monitor_ref[i] && !mon_d[i]) n_mon[i]++;
        end
        loop_d <= loop_ref;
        mon_d <= monitor_ref;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        check("reg_rdata", reg_rdata, exp);
        @(negedge clk);
    endtask
    // 24 input pulses: divide by 2, 3 and 4 all give whole counts
    task automatic route(logic [7:0] cfg, int el, int em);
        int ex_loop;
        int ex_mon;
        wr(8'h22, cfg);
        repeat (6) @(negedge clk);
        for (int i = 0; i < 5; i++) begin
            n_loop[i] = 0;
            n_mon[i] = 0;
        end
        repeat (24) begin
            ref_in = '1;
            repeat (2) @(negedge clk);
            ref_in = '0;
            repeat (2) @(negedge clk);
        end
        repeat (6) @(negedge clk);
        check("loop_edges", n_loop[0], el);
        check("monitor_edges", n_mon[0], em);
        // Other inputs keep their own settings and divider state
        for (int i = 1; i < 5; i++) begin
            ex_mon = VALS[i][7] ? 24 / prog_ratio : 24;
            ex_loop = VALS[i][7] ? ex_mon : (VALS[i][6] ? 6 : 24);
            check("other_loop_edges", n_loop[i], ex_loop);
            check("other_monitor_edges", n_mon[i], ex_mon);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence; inputs move on the falling edge only
    initial begin
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 5; i++) rd(IRC_CFG_OFFSET[i], DFLT[i]);
        for (int i = 0; i < 5; i++) begin
            wr(IRC_CFG_OFFSET[i], VALS[i]);
            check("profile", activity_monitor_profile[i], VALS[i][5:4]);
        end
        wr(8'h26, 8'hff);
        rd(8'h26, 8'h00);
        for (int i = 0; i < 5; i++) rd(IRC_CFG_OFFSET[i], VALS[i]);
        route(8'h00, 24, 24);
        route(8'h80, 12, 12);
        route(8'h40, 6, 24);
        route(8'hc0, 12, 12);
        prog_ratio = 4'h3;
        route(8'h80, 8, 8);
        // Mid-run reset brings every input back to its own default
        reset_n = 1'b0;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 5; i++) begin
            check("prof", activity_monitor_profile[i], DFLT[i][5:4]);
            rd(IRC_CFG_OFFSET[i], DFLT[i]);
        end
        end_of_test();
    end
    // Watchdog well beyond the roughly 24 us the tests take
    initial begin
        #100us;
        num_errors++;
        end_of_test();
    end
endmodule // irc_input_ref_conditioning_cfg_tb

bind irc_input_ref_conditioning_cfg irc_cfg_asserts #(.DIV_W(DIV_W)) u_chk (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .prog_div_ratio(prog_div_ratio), .fixed_div_ratio(fixed_div_ratio),
    .ref_in(ref_in), .loop_ref(loop_ref), .monitor_ref(monitor_ref),
    .activity_monitor_profile(activity_monitor_profile));
